// ### hdl/meb_map.vh
// Constants for the motor emergency brake sequencer.
// Assumes a 250 MHz clk_sys and an AHB-Lite master issuing single word transfers.
`ifndef MEB_MAP_VH
`define MEB_MAP_VH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define MEB_ADDR_MODE     8'h00
`define MEB_ADDR_MOTOR    8'h04
`define MEB_ADDR_DEMAG    8'h08
`define MEB_ADDR_DURATION 8'h0c
`define MEB_ADDR_SPEEDS   8'h10
`define MEB_ADDR_CURRENT  8'h14
`define MEB_ADDR_FAULTSEL 8'h18
`define MEB_ADDR_STATUS   8'h1c
`define MEB_ADDR_FAULTS   8'h20
`define MEB_ADDR_CTRL     8'h24

// ****************************************************************
// Mode selector values
// ****************************************************************
`define MEB_MODE_OFF      3'h0
`define MEB_MODE_EXT_FB   3'h1
`define MEB_MODE_EXT_NOFB 3'h2
`define MEB_MODE_GUARD    3'h3
`define MEB_MODE_INTERNAL 3'h4

// Motor type hundreds digit classes
`define MEB_MOTOR_IND     2'h1
`define MEB_MOTOR_ROT_PM  2'h2
`define MEB_MOTOR_LIN_PM  2'h0

// Fault response encodings
`define MEB_RESP_COAST    2'h0
`define MEB_RESP_BRAKE    2'h1
`define MEB_RESP_RAMP     2'h2

// Unsupported function fault value
`define MEB_UNSUP_VALUE   16'h0065

// Status word bits
`define MEB_ST_INITIATED  0
`define MEB_ST_CONTACTOR  1
`define MEB_ST_SHORT      2
`define MEB_ST_GUARD      3
`define MEB_ST_DEMAG      4
`define MEB_ST_RAMP       5
`define MEB_ST_DC         8

// Fault bits
`define MEB_F_PARAM       0
`define MEB_F_UNSUP       1
`define MEB_F_RESUME      2

// Control register bits
`define MEB_C_ENCODER     0
`define MEB_C_SERVO       1
`define MEB_C_FLYING      2

// Reset values
`define MEB_RST_DEMAG     32'h0000_0000
`define MEB_RST_ZERO      32'h0000_0000

`endif

// ### hdl/meb_sequencer.v
// Emergency brake sequencer: mode select, pulse gating, demag and DC timers.
// Assumes drive control supplies speed, fault events and resume status synchronous to clk_sys.
`include "meb_map.vh"
`default_nettype none

module meb_sequencer (
  input  wire        clk_sys,
  input  wire        reset_n,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire        hsel,
  input  wire        hready,
  input  wire [31:0] hwdata,
  output reg  [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  input  wire        brake_trigger_in,
  input  wire        fault_event,
  input  wire [15:0] fault_event_number,
  input  wire        coast_fault_active,
  input  wire        encoder_fault,
  input  wire [15:0] motor_speed,
  input  wire        motor_resume_ok,
  output reg         pulse_enable,
  output reg         contactor_close,
  output reg         half_bridge_short,
  output reg         guard_enable,
  output reg         dc_current_enable,
  output reg  [15:0] dc_current_level,
  output reg         ramp_down_active,
  output reg  [15:0] ramp_target_speed,
  output reg         control_resume,
  output reg         flying_restart_req,
  output reg         brake_initiated_flag,
  output reg  [15:0] brake_status_word,
  output reg         coast_stop_response,
  output reg         brake_param_fault,
  output reg  [15:0] unsup_fault_value
);

  // ****************************************************************
  // States
  // ****************************************************************
  localparam [6:0] S_IDLE   = 7'b000_0001;
  localparam [6:0] S_RAMP   = 7'b000_0010;
  localparam [6:0] S_CANCEL = 7'b000_0100;
  localparam [6:0] S_DEMAG  = 7'b000_1000;
  localparam [6:0] S_BRAKE  = 7'b001_0000;
  localparam [6:0] S_REDEM  = 7'b010_0000;
  localparam [6:0] S_RESUME = 7'b100_0000;

  // ****************************************************************
  // Registers
  // ****************************************************************
  reg [2:0]  brake_mode_select;
  reg [9:0]  motor_type_setting;
  reg [31:0] demag_time;
  reg [31:0] dc_brake_duration;
  reg [15:0] dc_brake_start_speed;
  reg [15:0] standstill_threshold;
  reg [15:0] dc_brake_current;
  reg [15:0] fault_number_select;
  reg [1:0]  fault_response_select;
  reg [1:0]  encoder_fault_response;
  reg [2:0]  ctrl;
  reg        internal_short_supported;
  reg [2:0]  faults;
  reg [6:0]  state;
  reg        from_fault;
  reg        is_dc;
  reg [31:0] timer;
  reg [9:0]  last_motor_type;
  reg        ap_valid;
  reg        ap_write;
  reg [7:0]  ap_addr;

  wire [1:0] motor_class = motor_type_setting[9:8];
  wire       motor_sync = (motor_class == `MEB_MOTOR_ROT_PM) ||
                          (motor_class == `MEB_MOTOR_LIN_PM);
  wire       mode_ext = (brake_mode_select == `MEB_MODE_EXT_FB) ||
                        (brake_mode_select == `MEB_MODE_EXT_NOFB);

  // Decoded fault request; coast stop always outranks it
  wire fault_hit = fault_event && (fault_event_number == fault_number_select) &&
                   (fault_response_select == `MEB_RESP_BRAKE);
  wire enc_hit   = encoder_fault && (encoder_fault_response == `MEB_RESP_BRAKE);
  wire fault_req = (fault_hit || enc_hit) && !coast_fault_active;
  wire start_req = brake_trigger_in || fault_req;

  // Prerequisites for current mode
  wire param_bad = mode_ext && !motor_sync;
  wire int_bad   = (brake_mode_select == `MEB_MODE_INTERNAL) && motor_sync &&
                   !internal_short_supported;

  // Zero timer setting gives an immediate transition
  function done_at;
    input [31:0] t;
    input [31:0] lim;
    begin
      done_at = (lim == 32'h0000_0000) || (t >= lim - 32'h0000_0001);
    end
  endfunction

  // ****************************************************************
  // AHB-Lite slave, zero wait states
  // ****************************************************************
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr  <= 8'h00;
    end else if (hready) begin
      ap_valid <= hsel && htrans[1];
      ap_write <= hwrite;
      ap_addr  <= haddr[7:0];
    end
  end

  wire wr = ap_valid && ap_write;

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      brake_mode_select        <= `MEB_MODE_OFF;
      motor_type_setting       <= 10'h000;
      demag_time               <= `MEB_RST_DEMAG;
      dc_brake_duration        <= `MEB_RST_ZERO;
      dc_brake_start_speed     <= 16'h0000;
      standstill_threshold     <= 16'h0000;
      dc_brake_current         <= 16'h0000;
      fault_number_select      <= 16'h0000;
      fault_response_select    <= `MEB_RESP_COAST;
      encoder_fault_response   <= `MEB_RESP_COAST;
      ctrl                     <= 3'h0;
      internal_short_supported <= 1'b0;
      last_motor_type          <= 10'h000;
    end else begin
      last_motor_type <= motor_type_setting;
      // Motor type change: an encoder brake response reverts to coast stop
      if (last_motor_type != motor_type_setting &&
          encoder_fault_response == `MEB_RESP_BRAKE) begin
        encoder_fault_response <= `MEB_RESP_COAST;
      end
      if (wr) begin
        case (ap_addr)
          `MEB_ADDR_MODE: begin
            brake_mode_select <= hwdata[2:0];
          end
          `MEB_ADDR_MOTOR: begin
            motor_type_setting       <= hwdata[9:0];
            internal_short_supported <= hwdata[16];
          end
          `MEB_ADDR_DEMAG: begin
            demag_time <= hwdata;
          end
          `MEB_ADDR_DURATION: begin
            dc_brake_duration <= hwdata;
          end
          `MEB_ADDR_SPEEDS: begin
            dc_brake_start_speed <= hwdata[15:0];
            standstill_threshold <= hwdata[31:16];
          end
          `MEB_ADDR_CURRENT: begin
            dc_brake_current <= hwdata[15:0];
          end
          `MEB_ADDR_FAULTSEL: begin
            fault_number_select    <= hwdata[15:0];
            fault_response_select  <= hwdata[17:16];
            encoder_fault_response <= hwdata[19:18];
          end
          `MEB_ADDR_CTRL: begin
            ctrl <= hwdata[2:0];
          end
          default: begin
          end
        endcase
      end
    end
  end

  always @* begin
    case (ap_addr)
      `MEB_ADDR_MODE:     hrdata = {29'h0, brake_mode_select};
      `MEB_ADDR_MOTOR:    hrdata = {15'h0, internal_short_supported, 6'h0, motor_type_setting};
      `MEB_ADDR_DEMAG:    hrdata = demag_time;
      `MEB_ADDR_DURATION: hrdata = dc_brake_duration;
      `MEB_ADDR_SPEEDS:   hrdata = {standstill_threshold, dc_brake_start_speed};
      `MEB_ADDR_CURRENT:  hrdata = {16'h0, dc_brake_current};
      `MEB_ADDR_FAULTSEL: hrdata = {12'h0, encoder_fault_response, fault_response_select,
                                    fault_number_select};
      `MEB_ADDR_STATUS:   hrdata = {16'h0, brake_status_word};
      `MEB_ADDR_FAULTS:   hrdata = {unsup_fault_value, 13'h0, faults};
      `MEB_ADDR_CTRL:     hrdata = {29'h0, ctrl};
      default:            hrdata = 32'h0000_0000;
    endcase
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  wire fault_clear = wr && (ap_addr == `MEB_ADDR_FAULTS);

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state      <= S_IDLE;
      from_fault <= 1'b0;
      is_dc      <= 1'b0;
      timer      <= 32'h0000_0000;
      faults     <= 3'h0;
      unsup_fault_value    <= 16'h0000;
      brake_initiated_flag <= 1'b0;
    end else begin
      // Write-one-to-clear; a new event in the same cycle wins
      if (fault_clear) begin
        faults <= faults & ~hwdata[2:0];
      end
      if (param_bad) begin
        faults[`MEB_F_PARAM] <= 1'b1;
      end
      case (state)
        S_IDLE: begin
          timer <= 32'h0000_0000;
          if (start_req && brake_mode_select != `MEB_MODE_OFF) begin
            if (int_bad) begin
              faults[`MEB_F_UNSUP] <= 1'b1;
              unsup_fault_value    <= `MEB_UNSUP_VALUE;
            end else if (!param_bad) begin
              from_fault <= !brake_trigger_in;
              brake_initiated_flag <= brake_trigger_in;
              is_dc <= (brake_mode_select == `MEB_MODE_INTERNAL) && !motor_sync;
              // Fault-driven DC brake ramps down first
              if (!brake_trigger_in && brake_mode_select == `MEB_MODE_INTERNAL &&
                  !motor_sync) begin
                state <= S_RAMP;
              end else begin
                state <= S_CANCEL;
              end
            end
          end
        end
        S_RAMP: begin
          if (motor_speed <= dc_brake_start_speed) begin
            state <= S_CANCEL;
          end
        end
        S_CANCEL: begin
          // Pulses are off for one cycle before any action
          state <= is_dc ? S_DEMAG : S_BRAKE;
        end
        S_DEMAG: begin
          timer <= timer + 32'h0000_0001;
          if (done_at(timer, demag_time)) begin
            timer <= 32'h0000_0000;
            state <= S_BRAKE;
          end
        end
        S_BRAKE: begin
          timer <= timer + 32'h0000_0001;
          if (is_dc && from_fault) begin
            // Encoder: brake to standstill; else fixed duration
            if (ctrl[`MEB_C_ENCODER] ? (motor_speed < standstill_threshold)
                                     : done_at(timer, dc_brake_duration)) begin
              timer <= 32'h0000_0000;
              state <= S_RESUME;
            end
          end else if (!start_req) begin
            // Trigger DC and all non-DC brakes: held while start_req stays high
            timer <= 32'h0000_0000;
            state <= (is_dc && ctrl[`MEB_C_SERVO] && ctrl[`MEB_C_ENCODER]) ?
                     S_REDEM : S_RESUME;
          end
        end
        S_REDEM: begin
          timer <= timer + 32'h0000_0001;
          if (done_at(timer, demag_time)) begin
            state <= S_RESUME;
          end
        end
        S_RESUME: begin
          if (!motor_resume_ok) begin
            faults[`MEB_F_RESUME] <= 1'b1;
          end
          brake_initiated_flag <= 1'b0;
          state <= S_IDLE;
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Outputs, registered
  // ****************************************************************
  wire braking = (state == S_CANCEL) || (state == S_DEMAG) || (state == S_BRAKE) ||
                 (state == S_REDEM);

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pulse_enable        <= 1'b0;
      contactor_close     <= 1'b0;
      half_bridge_short   <= 1'b0;
      guard_enable        <= 1'b0;
      dc_current_enable   <= 1'b0;
      dc_current_level    <= 16'h0000;
      ramp_down_active    <= 1'b0;
      ramp_target_speed   <= 16'h0000;
      control_resume      <= 1'b0;
      flying_restart_req  <= 1'b0;
      brake_status_word   <= 16'h0000;
      coast_stop_response <= 1'b0;
      brake_param_fault   <= 1'b0;
    end else begin
      pulse_enable <= !braking;
      // Contactor closes with pulses cancelled, only in external modes
      contactor_close <= mode_ext && motor_sync && !pulse_enable;
      // Guard armed whenever pulses are cancelled in guard mode
      guard_enable <= (brake_mode_select == `MEB_MODE_GUARD) && !pulse_enable;
      // Only the internal short mode may close a half-bridge; guard and contactor modes
      // also pass through the brake state
      half_bridge_short <= (state == S_BRAKE) && !is_dc &&
                           (brake_mode_select == `MEB_MODE_INTERNAL);
      dc_current_enable <= (state == S_BRAKE) && is_dc;
      dc_current_level  <= dc_brake_current;
      ramp_down_active  <= (state == S_RAMP);
      ramp_target_speed <= dc_brake_start_speed;
      // Rotor-oriented or selected control resumes
      control_resume <= (state == S_RESUME) && motor_resume_ok;
      flying_restart_req <= (state == S_RESUME) && is_dc && ctrl[`MEB_C_FLYING] &&
                            !ctrl[`MEB_C_SERVO];
      brake_status_word <= 16'h0000;
      brake_status_word[`MEB_ST_INITIATED] <= brake_initiated_flag;
      brake_status_word[`MEB_ST_CONTACTOR] <= contactor_close;
      brake_status_word[`MEB_ST_SHORT]     <= half_bridge_short;
      brake_status_word[`MEB_ST_GUARD]     <= guard_enable;
      brake_status_word[`MEB_ST_DEMAG]     <= (state == S_DEMAG) || (state == S_REDEM);
      brake_status_word[`MEB_ST_RAMP]      <= (state == S_RAMP);
      brake_status_word[`MEB_ST_DC]        <= dc_current_enable;
      coast_stop_response <= faults[`MEB_F_RESUME];
      brake_param_fault   <= faults[`MEB_F_PARAM];
    end
  end

endmodule

`default_nettype wire

// ### verif/meb_sequencer_props.sv
// Concurrent checks on the ports of the emergency brake sequencer.
// Assumes one clk_sys domain and an asynchronous active-low reset_n.
`default_nettype none
module meb_sequencer_props (
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire logic        pulse_enable,
  input wire logic        contactor_close,
  input wire logic        half_bridge_short,
  input wire logic        guard_enable,
  input wire logic        dc_current_enable,
  input wire logic        ramp_down_active,
  input wire logic        control_resume,
  input wire logic [15:0] brake_status_word,
  input wire logic [15:0] unsup_fault_value
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  one_function_a: assert property (
    $onehot0({contactor_close, half_bridge_short, guard_enable, dc_current_enable}))
    else $error("more than one brake function active");
  contactor_gated_a: assert property (
    $rose(contactor_close) |-> !pulse_enable ##1 brake_status_word[1])
    else $error("contactor closed with pulses on");
  short_gated_a: assert property (
    half_bridge_short |-> !pulse_enable) else $error("half bridge short with pulses on");
  demag_blocked_a: assert property (
    brake_status_word[4] |-> !pulse_enable) else $error("pulses on during demag");
  dc_status_a: assert property (
    dc_current_enable |-> !pulse_enable ##1 brake_status_word[8])
    else $error("dc brake without status bit");
  ramp_first_a: assert property (
    ramp_down_active |-> pulse_enable ##0 !dc_current_enable)
    else $error("ramp without pulses");
  unsup_value_a: assert property (
    (unsup_fault_value != 16'h0000) |-> unsup_fault_value == 16'h0065)
    else $error("wrong unsupported fault value");
  resume_pulse_a: assert property (
    control_resume |=> !control_resume) else $error("resume longer than one cycle");

  cover property (contactor_close);
  cover property (half_bridge_short);
  cover property ($rose(dc_current_enable) && !ramp_down_active);
  cover property (guard_enable);
endmodule

bind meb_sequencer meb_sequencer_props u_props (
  .clk_sys(clk_sys), .reset_n(reset_n), .pulse_enable(pulse_enable),
  .contactor_close(contactor_close), .half_bridge_short(half_bridge_short),
  .guard_enable(guard_enable), .dc_current_enable(dc_current_enable),
  .ramp_down_active(ramp_down_active), .control_resume(control_resume),
  .brake_status_word(brake_status_word), .unsup_fault_value(unsup_fault_value));
`default_nettype wire

// ### verif/meb_power_stage.sv
// Behavioural motor and power stage seen by the brake sequencer.
// Assumes the bench loads a start speed and chooses whether the motor can resume.
`default_nettype none
module meb_power_stage (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        pulse_enable,
  input  wire logic        contactor_close,
  input  wire logic        half_bridge_short,
  input  wire logic        dc_current_enable,
  input  wire logic        ramp_down_active,
  input  wire logic        load_speed,
  input  wire logic [15:0] speed_init,
  input  wire logic        stall_resume,
  output var  logic [15:0] motor_speed,
  output wire logic        motor_resume_ok
);
  timeunit 1ns;
  timeprecision 1ps;
  // Ramp, DC, short or contactor braking slows the shaft; guard and coasting keep speed so a slow ramp stays visible
  wire braking = ramp_down_active | dc_current_enable | half_bridge_short | contactor_close;
  assign motor_resume_ok = !stall_resume;
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      motor_speed <= 16'h0000;
    end else if (load_speed) begin
      motor_speed <= speed_init;
    end else if (braking && motor_speed >= 16'h0004) begin
      motor_speed <= motor_speed - 16'h0004;
    end
  end
endmodule
`default_nettype wire

// ### verif/meb_sequencer_test.sv
// Self-checking bench for the emergency brake sequencer.
// Assumes the register map of meb_map.vh and an always-ready AHB-Lite slave.
`include "meb_map.vh"
`default_nettype none
module meb_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys, reset_n, hwrite, hsel, brake_trigger_in, fault_event;
  logic        coast_fault_active, encoder_fault, load_speed, stall_resume;
  logic [31:0] haddr, hwdata, q;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [15:0] fault_event_number, speed_init;
  wire logic [31:0] hrdata;
  wire logic        hreadyout, hresp, pulse_enable, contactor_close, half_bridge_short;
  wire logic        guard_enable, dc_current_enable, ramp_down_active, control_resume;
  wire logic        flying_restart_req, brake_initiated_flag, coast_stop_response;
  wire logic        brake_param_fault, motor_resume_ok;
  wire logic [15:0] dc_current_level, ramp_target_speed, brake_status_word;
  wire logic [15:0] unsup_fault_value, motor_speed;
  int n_fail, samples_checked, i, c, n_res, n_fly;

  meb_sequencer DUT (.clk_sys, .reset_n, .haddr, .htrans, .hwrite, .hsize, .hsel,
    .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .brake_trigger_in,
    .fault_event, .fault_event_number, .coast_fault_active, .encoder_fault,
    .motor_speed, .motor_resume_ok, .pulse_enable, .contactor_close, .half_bridge_short,
    .guard_enable, .dc_current_enable, .dc_current_level, .ramp_down_active,
    .ramp_target_speed, .control_resume, .flying_restart_req, .brake_initiated_flag,
    .brake_status_word, .coast_stop_response, .brake_param_fault, .unsup_fault_value);
  meb_power_stage u_stage (.clk_sys, .reset_n, .pulse_enable, .contactor_close,
    .half_bridge_short, .dc_current_enable, .ramp_down_active, .load_speed, .speed_init,
    .stall_resume, .motor_speed, .motor_resume_ok);

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // Resume is a single-cycle pulse, so it is counted rather than polled
  always @(posedge clk_sys) begin
    if (control_resume === 1'b1) n_res <= n_res + 1;
    if (flying_restart_req === 1'b1) n_fly <= n_fly + 1;
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    hsel <= 1'b1;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, {24'h00_0000, a}, d);
  endtask
  task automatic rd(input logic [7:0] a);
    bus(1'b0, {24'h00_0000, a}, 32'h0000_0000);
  endtask
  task automatic trig(input logic v);
    @(posedge clk_sys);
    brake_trigger_in <= v;
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    #100us;
    n_fail++;
    final_report;
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    {reset_n, hwrite, hsel, brake_trigger_in, fault_event, coast_fault_active} = 6'h00;
    {encoder_fault, load_speed, stall_resume} = 3'h0;
    {haddr, hwdata, htrans, hsize} = {64'h0, 2'h0, 3'h2};
    fault_event_number = 16'h0000;
    speed_init = 16'h0000;
    n_fail = 0;
    samples_checked = 0;
    n_res = 0;
    n_fly = 0;
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk("pulses after reset", pulse_enable, 1'b1);
    rd(`MEB_ADDR_STATUS);
    chk("status idle", q, 32'h0000_0000);
    rd(8'h40);
    chk("unmapped read", q, 32'h0000_0000);
    // External short, both modes, rotating then linear PM motor
    for (int m = 1; m <= 2; m++) begin
      wr(`MEB_ADDR_MOTOR, (m == 1) ? 32'h0000_0200 : 32'h0000_0000);
      wr(`MEB_ADDR_MODE, m);
      trig(1'b1);
      for (i = 0; i < 300 && contactor_close !== 1'b1; i++) @(posedge clk_sys);
      chk("contactor", contactor_close, 1'b1);
      chk("pulses cut", pulse_enable, 1'b0);
      chk("initiated", brake_initiated_flag, 1'b1);
      chk("param ok", brake_param_fault, 1'b0);
      rd(`MEB_ADDR_STATUS);
      chk("status ext", q[2:0], 3'h3);
      trig(1'b0);
      for (i = 0; i < 300 && pulse_enable !== 1'b1; i++) @(posedge clk_sys);
      // Contactor follows the pulse gate one clock later
      @(posedge clk_sys);
      chk("contactor open", contactor_close, 1'b0);
    end
    // Induction motor refused for external short
    wr(`MEB_ADDR_MOTOR, 32'h0000_0100);
    repeat (3) @(posedge clk_sys);
    chk("param fault", brake_param_fault, 1'b1);
    trig(1'b1);
    repeat (20) @(posedge clk_sys);
    chk("refused", {pulse_enable, contactor_close}, 2'h2);
    trig(1'b0);
    rd(`MEB_ADDR_FAULTS);
    chk("fault reg", q[0], 1'b1);
    // Internal short without module support, then with it
    wr(`MEB_ADDR_MOTOR, 32'h0000_0200);
    wr(`MEB_ADDR_MODE, 32'h0000_0004);
    trig(1'b1);
    repeat (20) @(posedge clk_sys);
    chk("unsup value", unsup_fault_value, 16'h0065);
    chk("no short", half_bridge_short, 1'b0);
    trig(1'b0);
    repeat (20) @(posedge clk_sys);
    wr(`MEB_ADDR_MOTOR, 32'h0001_0200);
    wr(`MEB_ADDR_FAULTS, 32'h0000_0007);
    c = n_res;
    trig(1'b1);
    for (i = 0; i < 300 && half_bridge_short !== 1'b1; i++) @(posedge clk_sys);
    chk("short", {half_bridge_short, pulse_enable}, 2'h2);
    trig(1'b0);
    repeat (40) @(posedge clk_sys);
    chk("short resume", n_res == c + 1, 1'b1);
    chk("short pulses", pulse_enable, 1'b1);
    // Guard mode
    wr(`MEB_ADDR_MODE, 32'h0000_0003);
    trig(1'b1);
    for (i = 0; i < 300 && guard_enable !== 1'b1; i++) @(posedge clk_sys);
    chk("guard", {guard_enable, pulse_enable}, 2'h2);
    trig(1'b0);
    repeat (40) @(posedge clk_sys);
    // Trigger DC brake on an induction motor above the start speed
    wr(`MEB_ADDR_MOTOR, 32'h0000_0100);
    wr(`MEB_ADDR_DEMAG, 32'h0000_0008);
    wr(`MEB_ADDR_DURATION, 32'h0000_0010);
    wr(`MEB_ADDR_SPEEDS, 32'h0010_0050);
    wr(`MEB_ADDR_CURRENT, 32'h0000_0123);
    wr(`MEB_ADDR_MODE, 32'h0000_0004);
    speed_init <= 16'h0300;
    load_speed <= 1'b1;
    @(posedge clk_sys);
    load_speed <= 1'b0;
    trig(1'b1);
    for (i = 0; i < 300 && pulse_enable !== 1'b0; i++) @(posedge clk_sys);
    for (c = 0; c < 300 && dc_current_enable !== 1'b1; c++) @(posedge clk_sys);
    chk("demag span", c >= 8 && c <= 10, 1'b1);
    chk("no ramp", ramp_down_active, 1'b0);
    chk("dc level", dc_current_level, 16'h0123);
    repeat (30) @(posedge clk_sys);
    chk("dc held", dc_current_enable, 1'b1);
    rd(`MEB_ADDR_STATUS);
    chk("dc status", q[8], 1'b1);
    wr(`MEB_ADDR_CTRL, 32'h0000_0004);
    c = n_res;
    trig(1'b0);
    repeat (40) @(posedge clk_sys);
    chk("dc off", dc_current_enable, 1'b0);
    chk("dc resume", n_res == c + 1, 1'b1);
    chk("flying", n_fly, 1);
    // Fault response DC brake, blocked first by a coast stop
    wr(`MEB_ADDR_FAULTSEL, 32'h0001_0abc);
    speed_init <= 16'h0200;
    load_speed <= 1'b1;
    coast_fault_active <= 1'b1;
    fault_event_number <= 16'h0abc;
    fault_event <= 1'b1;
    @(posedge clk_sys);
    {load_speed, fault_event} <= 2'h0;
    repeat (20) @(posedge clk_sys);
    chk("coast wins", {ramp_down_active, pulse_enable}, 2'h1);
    coast_fault_active <= 1'b0;
    stall_resume <= 1'b1;
    fault_event <= 1'b1;
    @(posedge clk_sys);
    fault_event <= 1'b0;
    for (i = 0; i < 20 && ramp_down_active !== 1'b1; i++) @(posedge clk_sys);
    chk("ramp", ramp_down_active, 1'b1);
    chk("ramp target", ramp_target_speed, 16'h0050);
    for (i = 0; i < 600 && dc_current_enable !== 1'b1; i++) @(posedge clk_sys);
    chk("speed reached", motor_speed <= 16'h0050, 1'b1);
    for (c = 0; c < 300 && dc_current_enable === 1'b1; c++) @(posedge clk_sys);
    chk("dc duration", c >= 16 && c <= 17, 1'b1);
    repeat (40) @(posedge clk_sys);
    chk("resume fault", coast_stop_response, 1'b1);
    // Encoder fault brakes to standstill, then a motor type change drops that response
    wr(`MEB_ADDR_FAULTSEL, 32'h0004_0000);
    wr(`MEB_ADDR_SPEEDS, 32'h0004_0050);
    wr(`MEB_ADDR_CTRL, 32'h0000_0001);
    {load_speed, encoder_fault} <= 2'h3;
    @(posedge clk_sys);
    {load_speed, encoder_fault} <= 2'h0;
    for (i = 0; i < 600 && dc_current_enable !== 1'b1; i++) @(posedge clk_sys);
    for (i = 0; i < 300 && dc_current_enable === 1'b1; i++) @(posedge clk_sys);
    chk("standstill", motor_speed < 16'h0004, 1'b1);
    wr(`MEB_ADDR_MOTOR, 32'h0000_0200);
    rd(`MEB_ADDR_FAULTSEL);
    chk("enc revert", q[19:18], 2'h0);
    final_report;
  end
endmodule
`default_nettype wire
